// ---- pesw_asserts.sv ----
// assertion checker for the phy energy sleep and wake block
`timescale 1ns/1ns
`default_nettype none
module pesw_asserts (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic energy_sleep_enable,
	input wire logic energy_sleep_mode,
	input wire logic transceiver_power_up,
	input wire logic tx_enable,
	input wire logic fibre_mode,
	input wire logic efficiency_active,
	input wire logic rx_frame_end,
	input wire logic rx_frame_good,
	input wire logic [47:0] rx_dest_addr,
	input wire logic [47:0] wake_addr,
	input wire logic [3:0] wake_ctrl_enable,
	input wire logic [3:0] wake_ctrl_received,
	input wire logic wake_event_flag,
	input wire logic irq_flag_clr_wake,
	input wire logic wake_combined,
	input wire logic pm_event,
	input wire logic [15:0] power_mgmt_control,
	input wire logic energy_event_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_sleep_dark_line: assert property (
		energy_sleep_mode |-> !transceiver_power_up && !tx_enable) else $error("sleep with transceiver up");
	a_sleep_needs_en: assert property (
		$rose(energy_sleep_mode) |-> $past(energy_sleep_enable)) else $error("sleep entered while disabled");
	a_fibre_no_eff: assert property (
		$past(fibre_mode) |-> !efficiency_active) else $error("efficiency active in fibre mode");
	a_exact_match_sets: assert property (
		rx_frame_end && rx_frame_good && wake_ctrl_enable[0] && rx_dest_addr == wake_addr
		|=> wake_ctrl_received[0] && wake_event_flag) else $error("exact match not flagged");
	a_recv_has_cause: assert property (
		$rose(wake_ctrl_received[0]) |-> $past(rx_frame_end && rx_frame_good && wake_ctrl_enable[0]))
		else $error("received bit without good enabled frame");
	a_combined_and_or: assert property (
		wake_combined == $past(|(wake_ctrl_received & wake_ctrl_enable))) else $error("combined wake wrong");
	a_pm_route_bit: assert property (
		pm_event == $past(power_mgmt_control[14] && (energy_event_flag || wake_combined)))
		else $error("pm event routing wrong");
	a_wake_flag_sticky: assert property (
		wake_event_flag && !irq_flag_clr_wake |=> wake_event_flag) else $error("wake flag dropped");
endmodule // pesw_asserts
bind pesw_phy_sleep_wake pesw_asserts i_pesw_asserts (.*);
`default_nettype wire

// ---- pesw_defs.vh ----
// constants for the phy energy sleep and wake block
`ifndef PESW_DEFS_VH
`define PESW_DEFS_VH
`define PESW_WAKE_FLAG_BIT 8
`define PESW_PMT_PHY_A_BIT 14
`define PESW_PMT_PHY_B_BIT 15
`define PESW_WAKE_EXACT 0
`define PESW_WAKE_ALL_ONES 1
`define PESW_WAKE_MAGIC 2
`define PESW_WAKE_PATTERN 3
`define PESW_NLP_TX_BASE_NS 16000000
`define PESW_CLK_PERIOD_NS 8
`define PESW_NLP_TX_BASE_CYC (`PESW_NLP_TX_BASE_NS / `PESW_CLK_PERIOD_NS)
`define PESW_NLP_RX_BASE_NS 16000000
`define PESW_NLP_RX_BASE_CYC (`PESW_NLP_RX_BASE_NS / `PESW_CLK_PERIOD_NS)
`define PESW_BCAST_ADDR 48'hFFFFFFFFFFFF
`define PESW_WAKE_RST 4'h0
`endif

// ---- pesw_partner.sv ----
// behavioural cable link partner
`timescale 1ns/1ns
`default_nettype none
module pesw_partner (
	input wire logic sys_clk,
	output logic line_energy_raw,
	output logic rx_link_pulse_raw,
	output logic partner_efficiency_ok
);
	initial begin
		line_energy_raw = 1'b1;
		rx_link_pulse_raw = 1'b0;
		partner_efficiency_ok = 1'b1;
	end
	task automatic energy(input logic on);
		@(negedge sys_clk) line_energy_raw = on;
	endtask
	// pulse held several clocks so the synchroniser cannot miss it; line energy is left alone
	// so that the pulse path, not the energy path, is what wakes the block
	task automatic nlp();
		@(negedge sys_clk) rx_link_pulse_raw = 1'b1;
		repeat (6) @(negedge sys_clk);
		rx_link_pulse_raw = 1'b0;
	endtask
endmodule // pesw_partner
`default_nettype wire

// ---- pesw_phy_sleep_wake.v ----
// per-port phy energy sleep, efficiency gating and wake-on-frame logic
`timescale 1ns/1ns
`default_nettype none
`include "pesw_defs.vh"

// Contract
// (R1) sleep enabled, no energy: transceiver down
// (R2) no energy in sleep: stay down, transmit nothing
// (R3) energy returns: power up, restore, flag
// (R4) first packets after wake may drop
// (R5) sleep enable clear: never power down
// (R6) sleep pulses only when enabled, interval selectable
// (R7) wake on one pulse or two within interval
// (R8) energy wake to pm output via bit 14/15
// (R9) efficiency enable defaults from strap inputs
// (R10) efficiency only when all conditions met
// (R11) capability and advert defaults follow enable
// (R12) no efficiency in fibre mode
// (R13) four wake enables, each gates its type
// (R14) every wake event sets flag bit 8
// (R15) wake event to pm output via bit 14/15
// (R16) wake registers survive software reset
// (R17) exact address match needs good frame
// (R18) exact match sets flag and status
// (R19) all-ones address match needs good frame
// (R20) all-ones match sets flag and status
// (R21) host loads address, enable, then mask
// (R22) combined wake is and of status, enable
// (R23) power-down does not reset config
// (R24) status set at good frame end, sticky
module pesw_phy_sleep_wake #(
	parameter NLP_TX_BASE = `PESW_NLP_TX_BASE_CYC,
	parameter NLP_RX_BASE = `PESW_NLP_RX_BASE_CYC,
	parameter PHY_INDEX = 0
) (
	input wire sys_clk,
	input wire nrst,
	input wire soft_rst,

	// sleep and link pulse controls
	input wire energy_sleep_enable,
	input wire line_energy_raw,
	input wire rx_link_pulse_raw,
	input wire tx_nlp_enable,
	input wire [1:0] tx_nlp_interval_sel,
	input wire rx_single_nlp_wake,
	input wire [1:0] rx_nlp_max_interval_sel,

	// efficiency controls and link state
	input wire [1:0] efficiency_strap,
	input wire efficiency_enable_wr,
	input wire efficiency_enable_wdata,
	input wire efficiency_advert_wr,
	input wire efficiency_advert_wdata,
	input wire mac_efficiency_ok,
	input wire partner_efficiency_ok,
	input wire link_100tx_full,
	input wire fibre_mode,

	// power management, wake configuration and frame verdicts
	input wire [15:0] power_mgmt_control,
	input wire [3:0] wake_enable_wdata,
	input wire wake_enable_wr,
	input wire wake_configured_wdata,
	input wire wake_configured_wr,
	input wire [3:0] wake_status_clr,
	input wire [47:0] wake_addr,
	input wire [47:0] rx_dest_addr,
	input wire rx_frame_end,
	input wire rx_frame_good,
	input wire rx_ext_match_magic,
	input wire rx_ext_match_pattern,
	input wire irq_flag_clr_energy,
	input wire irq_flag_clr_wake,

	// every output comes straight from a flop
	output reg transceiver_power_up,
	output reg tx_enable,
	output reg tx_nlp_pulse,
	output reg energy_present,
	output reg energy_sleep_mode,
	output reg energy_event_flag,
	output reg wake_event_flag,
	output reg [3:0] wake_ctrl_enable,
	output reg [3:0] wake_ctrl_received,
	output reg wake_configured,
	output reg wake_combined,
	output reg efficiency_enable,
	output reg efficiency_capability,
	output reg efficiency_advert,
	output reg efficiency_active,
	output reg pm_event
);

	// one-hot sleep states; the half state waits for a second link pulse
	localparam ST_AWAKE = 3'b001;
	localparam ST_SLEEP = 3'b010;
	localparam ST_HALF = 3'b100;
	localparam PM_BIT = (PHY_INDEX == 0) ? `PESW_PMT_PHY_A_BIT : `PESW_PMT_PHY_B_BIT;

	// state, synchroniser and interval counter flops
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] energy_sync_reg;
	reg [2:0] pulse_sync_reg;
	reg energy_clean_reg;
	reg pulse_clean_reg;
	reg pulse_prev_reg;
	reg [25:0] tx_cnt_reg;
	reg [25:0] rx_cnt_reg;
	reg strap_taken_reg;

	// combinational helpers
	wire energy_hit;
	wire pulse_hit;
	wire [25:0] tx_limit;
	wire [25:0] rx_limit;
	wire [3:0] frame_hit;
	wire wake_any;

	// the first stage of each chain is read only by the second
	// a change counts once the last two sync stages agree
	always @(posedge sys_clk) begin
		if (!nrst) begin
			energy_sync_reg <= 3'b000;
			pulse_sync_reg <= 3'b000;
			energy_clean_reg <= 1'b0;
			pulse_clean_reg <= 1'b0;
			pulse_prev_reg <= 1'b0;
		end else begin

			energy_sync_reg <= {energy_sync_reg[1:0], line_energy_raw};
			pulse_sync_reg <= {pulse_sync_reg[1:0], rx_link_pulse_raw};

			if (energy_sync_reg[2] == energy_sync_reg[1])
				energy_clean_reg <= energy_sync_reg[2];
			if (pulse_sync_reg[2] == pulse_sync_reg[1])
				pulse_clean_reg <= pulse_sync_reg[2];

			pulse_prev_reg <= pulse_clean_reg;
		end
	end

	// a link pulse is itself energy on the line
	assign pulse_hit = pulse_clean_reg & ~pulse_prev_reg;
	assign energy_hit = energy_clean_reg | pulse_hit;
	assign tx_limit = NLP_TX_BASE[25:0] << tx_nlp_interval_sel;
	assign rx_limit = NLP_RX_BASE[25:0] << rx_nlp_max_interval_sel;

	// each select step doubles the base interval; counters are sized for the largest step
	// sleep state machine; only transceiver power changes, config regs are untouched [R23]
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_AWAKE: begin
				if (energy_sleep_enable && !energy_clean_reg) // [R1] [R5]
					state_next = ST_SLEEP;
			end

			ST_SLEEP: begin
				if (!energy_sleep_enable) // [R5]
					state_next = ST_AWAKE;
				else if (energy_clean_reg) // [R3]
					state_next = ST_AWAKE;
				else if (pulse_hit)
					state_next = rx_single_nlp_wake ? ST_AWAKE : ST_HALF; // [R7]
			end

			ST_HALF: begin
				if (!energy_sleep_enable || energy_clean_reg || pulse_hit) // [R7]
					state_next = ST_AWAKE;
				else if (rx_cnt_reg >= rx_limit)
					state_next = ST_SLEEP;
			end

			default: state_next = ST_AWAKE;
		endcase
	end

	// power, tx enable and sleep mode follow state_next so they change on the same edge
	always @(posedge sys_clk) begin
		if (!nrst) begin
			state_reg <= ST_AWAKE;
			rx_cnt_reg <= 26'h0000000;
			tx_cnt_reg <= 26'h0000000;
			transceiver_power_up <= 1'b1;
			tx_enable <= 1'b1;
			tx_nlp_pulse <= 1'b0;
			energy_present <= 1'b0;
			energy_sleep_mode <= 1'b0;
			energy_event_flag <= 1'b0;
			pm_event <= 1'b0;
		end else begin

			state_reg <= state_next;
			rx_cnt_reg <= (state_reg == ST_HALF) ? rx_cnt_reg + 26'h0000001 : 26'h0000000;
			// the first packets after wake arrive before power-up completes and may be lost [R4]
			transceiver_power_up <= (state_next == ST_AWAKE); // [R1] [R2] [R3]
			tx_enable <= (state_next == ST_AWAKE); // [R2]
			energy_present <= energy_hit;
			energy_sleep_mode <= (state_next != ST_AWAKE);

			// link pulses are sent only while asleep, one clock wide
			tx_nlp_pulse <= 1'b0;
			if (state_reg != ST_AWAKE && tx_nlp_enable) begin // [R6]
				if (tx_cnt_reg >= tx_limit) begin
					tx_cnt_reg <= 26'h0000000;
					tx_nlp_pulse <= 1'b1;
				end else
					tx_cnt_reg <= tx_cnt_reg + 26'h0000001;
			end else
				tx_cnt_reg <= 26'h0000000;

			// set wins over clear
			if (state_reg != ST_AWAKE && state_next == ST_AWAKE && energy_sleep_enable)
				energy_event_flag <= 1'b1; // [R3]
			else if (irq_flag_clr_energy)
				energy_event_flag <= 1'b0;

			// one control bit gates both energy and wake events
			pm_event <= power_mgmt_control[PM_BIT] & (energy_event_flag | wake_combined); // [R8] [R15]
		end
	end

	// efficiency enable: strap default caught after reset release [R9]
	always @(posedge sys_clk) begin
		if (!nrst) begin
			strap_taken_reg <= 1'b0;
			efficiency_enable <= 1'b0;
			efficiency_capability <= 1'b0;
			efficiency_advert <= 1'b0;
			efficiency_active <= 1'b0;
		end else begin

			strap_taken_reg <= 1'b1;
			if (!strap_taken_reg)
				efficiency_enable <= efficiency_strap[PHY_INDEX]; // [R9]
			else if (efficiency_enable_wr)
				efficiency_enable <= efficiency_enable_wdata;

			efficiency_capability <= efficiency_enable; // [R11]
			if (!strap_taken_reg || efficiency_enable_wr)
				efficiency_advert <= strap_taken_reg ? efficiency_enable_wdata : efficiency_strap[PHY_INDEX]; // [R11]
			else if (efficiency_advert_wr)
				efficiency_advert <= efficiency_advert_wdata;

			// active only while every condition holds; fibre always blocks it
			efficiency_active <= efficiency_enable & efficiency_advert & mac_efficiency_ok &
				partner_efficiency_ok & link_100tx_full & ~fibre_mode; // [R10] [R12]
		end
	end

	// frame matches count only on a good frame end [R17] [R19] [R24]
	assign frame_hit[`PESW_WAKE_EXACT] = rx_frame_end & rx_frame_good & (rx_dest_addr == wake_addr); // [R17]
	assign frame_hit[`PESW_WAKE_ALL_ONES] = rx_frame_end & rx_frame_good & (rx_dest_addr == `PESW_BCAST_ADDR); // [R19]
	assign frame_hit[`PESW_WAKE_MAGIC] = rx_frame_end & rx_frame_good & rx_ext_match_magic;
	assign frame_hit[`PESW_WAKE_PATTERN] = rx_frame_end & rx_frame_good & rx_ext_match_pattern;
	// magic and pattern verdicts come from matchers outside this block
	assign wake_any = |(frame_hit & wake_ctrl_enable); // [R13]

	// the host loads the address and enable before unmasking bit 8 [R21]
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_wake
			// hard reset only: software reset leaves wake state alone [R16]
			always @(posedge sys_clk) begin
				if (!nrst)
					wake_ctrl_received[gi] <= 1'b0;
				else if (frame_hit[gi] && wake_ctrl_enable[gi]) // [R13] [R18] [R20] [R24]
					wake_ctrl_received[gi] <= 1'b1;
				else if (wake_status_clr[gi])
					wake_ctrl_received[gi] <= 1'b0;
			end
		end
	endgenerate

	// enable and configured bits are host written and cleared only by nrst
	always @(posedge sys_clk) begin
		if (!nrst) begin
			wake_ctrl_enable <= `PESW_WAKE_RST;
			wake_configured <= 1'b0;
			wake_combined <= 1'b0;
			wake_event_flag <= 1'b0;
		end else begin

			if (wake_enable_wr) // [R16]
				wake_ctrl_enable <= wake_enable_wdata;
			if (wake_configured_wr) // [R16]
				wake_configured <= wake_configured_wdata;

			wake_combined <= |(wake_ctrl_received & wake_ctrl_enable); // [R22]

			if (wake_any) // [R14] [R18] [R20]
				wake_event_flag <= 1'b1;
			else if (irq_flag_clr_wake)
				wake_event_flag <= 1'b0;
		end
	end

endmodule // pesw_phy_sleep_wake
`default_nettype wire

// ---- pesw_phy_sleep_wake_tb.sv ----
// self-checking testbench for the phy energy sleep and wake block
`timescale 1ns/1ns
`default_nettype none
module pesw_phy_sleep_wake_tb;
	logic sys_clk = 1'b0;
	logic nrst, soft_rst, energy_sleep_enable, tx_nlp_enable, rx_single_nlp_wake, efficiency_enable_wr;
	logic efficiency_enable_wdata, efficiency_advert_wr, efficiency_advert_wdata, mac_efficiency_ok;
	logic link_100tx_full, fibre_mode, wake_enable_wr, wake_configured_wdata, wake_configured_wr;
	logic rx_frame_end, rx_frame_good, rx_ext_match_magic, rx_ext_match_pattern, irq_flag_clr_energy;
	logic irq_flag_clr_wake;
	logic [1:0] tx_nlp_interval_sel, rx_nlp_max_interval_sel, efficiency_strap;
	logic [3:0] wake_enable_wdata, wake_status_clr, wake_ctrl_enable, wake_ctrl_received;
	logic [15:0] power_mgmt_control;
	logic [47:0] wake_addr, rx_dest_addr;
	wire logic line_energy_raw, rx_link_pulse_raw, partner_efficiency_ok;
	logic transceiver_power_up, tx_enable, tx_nlp_pulse, energy_present, energy_sleep_mode, energy_event_flag;
	logic wake_event_flag, wake_configured, wake_combined, efficiency_enable, efficiency_capability;
	logic efficiency_advert, efficiency_active, pm_event;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	always #4 sys_clk = ~sys_clk;
	pesw_phy_sleep_wake #(.NLP_TX_BASE(20), .NLP_RX_BASE(20)) i_pesw_phy_sleep_wake (.*);
	pesw_partner i_pesw_partner (.sys_clk(sys_clk), .line_energy_raw(line_energy_raw),
		.rx_link_pulse_raw(rx_link_pulse_raw), .partner_efficiency_ok(partner_efficiency_ok));
	task automatic give_verdict();
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic frame(input logic [47:0] da, input logic good, input logic magic);
		@(negedge sys_clk);
		{rx_dest_addr, rx_frame_good, rx_ext_match_magic, rx_frame_end} = {da, good, magic, 1'b1};
		@(negedge sys_clk) rx_frame_end = 1'b0;
		@(negedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		{nrst, soft_rst, energy_sleep_enable, tx_nlp_enable, rx_single_nlp_wake, efficiency_enable_wr,
			efficiency_enable_wdata, efficiency_advert_wr, efficiency_advert_wdata, mac_efficiency_ok,
			link_100tx_full, fibre_mode, wake_configured_wr, rx_frame_end, rx_frame_good, rx_ext_match_magic,
			rx_ext_match_pattern, irq_flag_clr_energy, irq_flag_clr_wake, tx_nlp_interval_sel,
			rx_nlp_max_interval_sel, wake_status_clr, rx_dest_addr} = 0;
		{efficiency_strap, power_mgmt_control, wake_addr} = {2'h1, 16'h4000, 48'h00123456789A};
		{wake_enable_wr, wake_enable_wdata, wake_configured_wdata} = {1'b1, 4'h3, 1'b1};
		repeat (16) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk("power_up", transceiver_power_up, 1);
		chk("eff_enable", efficiency_enable, 1);
		chk("eff_cap_adv", {efficiency_capability, efficiency_advert}, 3);
		{mac_efficiency_ok, link_100tx_full, wake_enable_wr, wake_configured_wr} = 4'hD;
		@(negedge sys_clk) wake_configured_wr = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("eff_active", efficiency_active, 1);
		fibre_mode = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("eff_fibre", efficiency_active, 0);
		frame(wake_addr ^ 48'h1, 1, 0);
		frame(wake_addr, 0, 0);
		chk("received_miss", wake_ctrl_received, 0);
		frame(wake_addr, 1, 0);
		chk("received_exact", {wake_ctrl_received, wake_event_flag}, 3);
		repeat (2) @(negedge sys_clk);
		chk("pm_event", pm_event, 1);
		frame(48'hFFFFFFFFFFFF, 0, 0);
		chk("bcast_bad", wake_ctrl_received, 1);
		frame(48'hFFFFFFFFFFFF, 1, 1);
		chk("bcast_magic_off", wake_ctrl_received, 3);
		chk("combined", {wake_ctrl_enable, wake_combined}, 8'h07);
		@(negedge sys_clk) soft_rst = 1'b1;
		@(negedge sys_clk) soft_rst = 1'b0;
		chk("survive_soft", {wake_configured, wake_ctrl_received}, 8'h13);
		@(negedge sys_clk) {wake_status_clr, irq_flag_clr_wake} = 5'h03;
		@(negedge sys_clk) {wake_status_clr, irq_flag_clr_wake} = 5'h00;
		chk("clear_wake", {wake_ctrl_received, wake_event_flag}, 8'h04);
		{energy_sleep_enable, tx_nlp_enable} = 2'h3;
		i_pesw_partner.energy(0);
		for (n = 0; n < 60 && transceiver_power_up !== 1'b0; n++) @(negedge sys_clk);
		chk("sleep_tx", {transceiver_power_up, tx_enable}, 0);
		chk("sleep_mode", {energy_sleep_mode, energy_present}, 8'h02);
		for (n = 0; n < 120 && tx_nlp_pulse !== 1'b1; n++) @(negedge sys_clk);
		chk("nlp_pulse", tx_nlp_pulse, 1);
		rx_single_nlp_wake = 1'b1;
		i_pesw_partner.nlp();
		chk("wake_one_nlp", energy_event_flag, 1);
		@(negedge sys_clk) {rx_single_nlp_wake, irq_flag_clr_energy} = 2'h1;
		@(negedge sys_clk) irq_flag_clr_energy = 1'b0;
		i_pesw_partner.nlp();
		repeat (30) @(negedge sys_clk);
		chk("one_of_two_nlp", {transceiver_power_up, energy_event_flag}, 0);
		i_pesw_partner.nlp();
		repeat (4) @(negedge sys_clk);
		i_pesw_partner.nlp();
		chk("two_nlp_wake", energy_event_flag, 1);
		i_pesw_partner.energy(1);
		for (n = 0; n < 40 && transceiver_power_up !== 1'b1; n++) @(negedge sys_clk);
		repeat (2) @(negedge sys_clk);
		chk("wake_energy", {transceiver_power_up, tx_enable, energy_present, energy_sleep_mode}, 8'h0E);
		give_verdict();
	end
endmodule // pesw_phy_sleep_wake_tb
`default_nettype wire
